// ### pfsseq_pkg.sv
// Purpose: Shared constants and types for the program flash sequencer.
// Assumes: APB register window with byte addresses, 25 MHz core clock.
// Notes: Register offsets and bit positions live here only.
package pfsseq_pkg;

    // Core clock and long write timing
    localparam int CLK_HZ = 25_000_000;
    localparam int LONG_WRITE_MS = 2;
    localparam int LONG_WRITE_CYC = LONG_WRITE_MS * (CLK_HZ / 1000);
    localparam int TMR_W = 16;

    // Address widths of the pointer and its fields
    localparam int PTR_W = 22;
    localparam int PTR_LOW_W = 21;
    localparam int WORD_ADDR_W = 21;
    localparam int ROW_W = 16;
    localparam int ROW_LSB = 6;
    localparam int BLK_W = 19;
    localparam int BLK_LSB = 3;
    localparam int HOLD_IDX_W = 3;
    localparam int HOLD_N = 8;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_KEY = 8'h04;
    localparam logic [7:0] ADDR_PTR = 8'h08;
    localparam logic [7:0] ADDR_LATCH = 8'h0C;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;

    // Memory control register bit positions
    localparam int CTL_PSS = 7;
    localparam int CTL_ERASE = 4;
    localparam int CTL_ABORT = 3;
    localparam int CTL_PERMIT = 2;
    localparam int CTL_WR = 1;

    // Table command register fields
    localparam int CMD_OP = 0;
    localparam int CMD_MODE_LSB = 1;
    localparam logic [1:0] MODE_KEEP = 2'h0;
    localparam logic [1:0] MODE_POST_INC = 2'h1;
    localparam logic [1:0] MODE_POST_DEC = 2'h2;
    localparam logic [1:0] MODE_PRE_INC = 2'h3;

    // Status register bit positions
    localparam int STAT_DONE = 0;
    localparam int STAT_BUSY = 1;

    // Unlock key values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // Sequencer states, one bit flips per step except table read data back to idle
    typedef enum logic [1:0] {
        PFS_IDLE = 2'b00,
        PFS_TRD_ADDR = 2'b01,
        PFS_TRD_DATA = 2'b11,
        PFS_LONG = 2'b10
    } pfs_state_t;

    // Unlock progress
    typedef enum logic [1:0] {
        UNLK_NONE = 2'b00,
        UNLK_GOT55 = 2'b01,
        UNLK_ARMED = 2'b11
    } pfs_unlk_t;

endpackage

// ### pfsseq_timer.sv
// Purpose: Down counter that times one long write.
// Assumes: Start is a one-cycle pulse while idle.
// Notes: Expiry is a one-cycle pulse on the last count.
`timescale 1ns/1ps
module pfsseq_timer
    import pfsseq_pkg::*;
#(
    parameter int W = TMR_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [W-1:0] i_load,
    output logic o_expired,
    output logic o_running
);

    typedef struct packed {
        logic run;
        logic [W-1:0] cnt;
    } pfsseq_tmr_t;

    pfsseq_tmr_t s;
    pfsseq_tmr_t next_s;

    // Count down while running, stop at one
    always_comb begin
        next_s = s;
        o_expired = 1'b0;
        if (i_start) begin
            next_s.run = 1'b1;
            next_s.cnt = i_load;
        end else if (s.run) begin
            if (s.cnt <= W'(1)) begin
                next_s.run = 1'b0;
                o_expired = 1'b1;
            end else begin
                next_s.cnt = s.cnt - W'(1);
            end
        end
    end

    assign o_running = s.run;

    // State register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule

// ### pfsseq_top.sv
// Purpose: Self-programming sequencer for the on-chip program flash.
// Assumes: APB slave, flash array answers a read one cycle after enable.
// Notes: A long write stalls the core and holds off APB answers.
// Function
// (RULE_01) Each table read fetches one byte at the pointer into the latch.
// (RULE_02) Pointer bit zero picks low or high byte of the 16-bit word.
// (RULE_03) Table ops may step the pointer before or after the access.
// (RULE_04) A self erase always clears a whole 64-byte row.
// (RULE_05) Erase row comes from pointer bits 21 to 6; low six ignored.
// (RULE_06) Software sets program space, write permit and erase select first.
// (RULE_07) Key 55h then AAh must precede the write-start bit.
// (RULE_08) Write-start with erase selected begins a timed 2 ms row erase.
// (RULE_09) Execution halts during a long write until the timer expires.
// (RULE_10) Software masks interrupts around unlock and runs one nop after.
// (RULE_11) Programming always commits an 8-byte block.
// (RULE_12) Eight byte-wide holding registers stage program data.
// (RULE_13) Table writes touch only the holding registers.
// (RULE_14) Software issues eight table writes then launches the long write.
// (RULE_15) Software loads pointer, fills holds, sets bits, unlocks, starts.
// (RULE_16) Each block program stalls the core about 2 ms.
// (RULE_17) Row update: read, modify, erase, then program eight blocks.
// (RULE_18) Software should verify written data with table reads.
// (RULE_19) Write-start is set-only by software, cleared by hardware at end.
// (RULE_20) Completion sets the done flag; software clears it.
// (RULE_21) Table write index is pointer 2:0; block is pointer 21:3.
// (RULE_22) A warm reset during a long write sets the abort flag.
// (RULE_23) No permit or no fresh unlock: start request is ignored.
// (RULE_24) Erase select clear means program; erase end clears the select.
`timescale 1ns/1ps
module pfsseq_top
    import pfsseq_pkg::*;
#(
    parameter int LONG_WRITE_CYCLES = LONG_WRITE_CYC
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_WARM_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic O_CPU_STALL,
    output logic O_NVM_DONE,
    output logic O_FL_RD_EN,
    output logic [WORD_ADDR_W-1:0] O_FL_RD_ADDR,
    input wire logic [15:0] I_FL_RD_DATA,
    output logic O_FL_ERASE,
    output logic [ROW_W-1:0] O_FL_ROW,
    output logic O_FL_PROG,
    output logic [BLK_W-1:0] O_FL_BLOCK,
    output logic [63:0] O_FL_WDATA
);

    typedef struct packed {
        pfs_state_t st;
        logic was_idle;
        pfs_unlk_t unlk;
        logic [PTR_W-1:0] ptr;
        logic [7:0] latch;
        logic [HOLD_N-1:0][7:0] hold;
        logic [1:0] mode;
        logic pss;
        logic erase;
        logic abort;
        logic permit;
        logic wr;
        logic done;
        logic [ROW_W-1:0] row;
        logic [BLK_W-1:0] blk;
        logic [63:0] wdata;
        logic [31:0] rdata;
    } pfsseq_state_t;

    localparam pfsseq_state_t RST_STATE = '{
        st: PFS_IDLE,
        unlk: UNLK_NONE,
        default: '0
    };

    pfsseq_state_t s;
    pfsseq_state_t next_s;

    logic acc;
    logic hit;
    logic is_trd;
    logic wr_ok;
    logic tmr_start;
    logic tmr_exp;
    logic [PTR_W-1:0] p_acc;
    logic [1:0] wmode;

    // Step the low 21 pointer bits; the top bit never moves
    function automatic logic [PTR_W-1:0] ptr_step(
        input logic [PTR_W-1:0] p,
        input logic down
    );
        logic [PTR_LOW_W-1:0] low;
        low = p[PTR_LOW_W-1:0];
        if (down) begin
            low = low - PTR_LOW_W'(1);
        end else begin
            low = low + PTR_LOW_W'(1);
        end
        return {p[PTR_W-1], low};
    endfunction

    // Long write duration counter
    pfsseq_timer #(
        .W(TMR_W)
    ) u_timer (
        .i_clk(I_CLK),
        .i_rst(I_RST | I_WARM_RST),
        .i_start(tmr_start),
        .i_load(TMR_W'(LONG_WRITE_CYCLES)),
        .o_expired(tmr_exp),
        .o_running()
    );

    // Address decode and answer timing
    always_comb begin
        acc = I_PSEL & I_PENABLE;
        hit = (I_PADDR == ADDR_CTRL) | (I_PADDR == ADDR_KEY)
            | (I_PADDR == ADDR_PTR) | (I_PADDR == ADDR_LATCH)
            | (I_PADDR == ADDR_CMD) | (I_PADDR == ADDR_STAT);
        is_trd = I_PWRITE & (I_PADDR == ADDR_CMD) & ~I_PWDATA[CMD_OP];
        // Answers wait one idle cycle so read data has settled
        O_PREADY = acc & ((s.st == PFS_IDLE & s.was_idle & ~is_trd)
            | s.st == PFS_TRD_DATA);                          // [RULE_09]
        O_PSLVERR = O_PREADY & ~hit;
        wr_ok = O_PREADY & I_PWRITE & hit;
    end

    // Sequencer next state
    always_comb begin
        next_s = s;
        tmr_start = 1'b0;
        wmode = I_PWDATA[CMD_MODE_LSB +: 2];
        p_acc = s.ptr;
        next_s.was_idle = (s.st == PFS_IDLE);
        // Read data captured each cycle from the register flops
        next_s.rdata = '0;
        unique case (I_PADDR)
            ADDR_CTRL: begin
                next_s.rdata[CTL_PSS] = s.pss;
                next_s.rdata[CTL_ERASE] = s.erase;
                next_s.rdata[CTL_ABORT] = s.abort;
                next_s.rdata[CTL_PERMIT] = s.permit;
                next_s.rdata[CTL_WR] = s.wr;
            end
            ADDR_PTR: next_s.rdata[PTR_W-1:0] = s.ptr;
            ADDR_LATCH: next_s.rdata[7:0] = s.latch;
            ADDR_STAT: begin
                next_s.rdata[STAT_DONE] = s.done;
                next_s.rdata[STAT_BUSY] = (s.st == PFS_LONG);
            end
            default: next_s.rdata = '0;
        endcase

        // Unlock tracker: any other write to a mapped register breaks the sequence
        if (wr_ok) begin
            next_s.unlk = UNLK_NONE;
            if (I_PADDR == ADDR_KEY) begin
                if (I_PWDATA[7:0] == KEY_FIRST) begin
                    next_s.unlk = UNLK_GOT55;                 // [RULE_07]
                end else if (I_PWDATA[7:0] == KEY_SECOND &&
                             s.unlk == UNLK_GOT55) begin
                    next_s.unlk = UNLK_ARMED;                 // [RULE_07]
                end
            end
        end

        unique case (s.st)
            PFS_IDLE: begin
                // Table read launch; answer comes with the byte
                if (acc & s.was_idle & is_trd) begin
                    next_s.mode = wmode;
                    if (wmode == MODE_PRE_INC) begin
                        next_s.ptr = ptr_step(s.ptr, 1'b0);   // [RULE_03]
                    end
                    next_s.st = PFS_TRD_ADDR;
                end
                if (wr_ok) begin
                    unique case (I_PADDR)
                        ADDR_CTRL: begin
                            next_s.pss = I_PWDATA[CTL_PSS];
                            next_s.erase = I_PWDATA[CTL_ERASE];
                            next_s.abort = I_PWDATA[CTL_ABORT];
                            next_s.permit = I_PWDATA[CTL_PERMIT];
                            // Start only with permit and a fresh unlock
                            if (I_PWDATA[CTL_WR] && s.unlk == UNLK_ARMED
                                && I_PWDATA[CTL_PERMIT]
                                && I_PWDATA[CTL_PSS]) begin   // [RULE_23]
                                next_s.wr = 1'b1;             // [RULE_07]
                                next_s.row = s.ptr[PTR_W-1:ROW_LSB];
                                next_s.blk = s.ptr[PTR_W-1:BLK_LSB];
                                next_s.wdata = s.hold;        // [RULE_11]
                                next_s.st = PFS_LONG;         // [RULE_08]
                                tmr_start = 1'b1;             // [RULE_16]
                            end
                        end
                        ADDR_PTR: next_s.ptr = I_PWDATA[PTR_W-1:0];
                        ADDR_LATCH: next_s.latch = I_PWDATA[7:0];
                        ADDR_CMD: begin
                            // Short write: holding register only
                            if (wmode == MODE_PRE_INC) begin
                                p_acc = ptr_step(s.ptr, 1'b0);
                            end
                            next_s.hold[p_acc[HOLD_IDX_W-1:0]] =
                                s.latch;                      // [RULE_13]
                            next_s.ptr = p_acc;               // [RULE_21]
                            if (wmode == MODE_POST_INC) begin
                                next_s.ptr = ptr_step(p_acc, 1'b0);
                            end else if (wmode == MODE_POST_DEC) begin
                                next_s.ptr = ptr_step(p_acc, 1'b1);
                            end
                        end
                        ADDR_STAT: begin
                            if (I_PWDATA[STAT_DONE]) begin
                                next_s.done = 1'b0;           // [RULE_20]
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            PFS_TRD_ADDR: begin
                next_s.st = PFS_TRD_DATA;
            end
            PFS_TRD_DATA: begin
                // Odd address takes the high byte of the word
                next_s.latch = s.ptr[0] ? I_FL_RD_DATA[15:8]
                    : I_FL_RD_DATA[7:0];                      // [RULE_02]
                if (s.mode == MODE_POST_INC) begin
                    next_s.ptr = ptr_step(s.ptr, 1'b0);       // [RULE_03]
                end else if (s.mode == MODE_POST_DEC) begin
                    next_s.ptr = ptr_step(s.ptr, 1'b1);       // [RULE_03]
                end
                next_s.st = PFS_IDLE;                         // [RULE_01]
            end
            PFS_LONG: begin
                // Timer end closes the cycle
                if (tmr_exp) begin
                    next_s.wr = 1'b0;                         // [RULE_19]
                    next_s.erase = 1'b0;                      // [RULE_24]
                    next_s.done = 1'b1;                       // [RULE_20]
                    next_s.st = PFS_IDLE;                     // [RULE_09]
                end
            end
        endcase

        // Warm reset drops everything but space select, kept for tracing, and the abort flag
        if (I_WARM_RST) begin
            next_s = RST_STATE;
            next_s.pss = s.pss;
            next_s.abort = s.abort | (s.st == PFS_LONG);      // [RULE_22]
        end
    end

    // State register, power-on reset
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    // Outputs toward the core and the array
    always_comb begin
        O_PRDATA = s.rdata;
        O_CPU_STALL = (s.st == PFS_LONG);                     // [RULE_09]
        O_NVM_DONE = s.done;
        O_FL_RD_EN = (s.st == PFS_TRD_ADDR);                  // [RULE_01]
        O_FL_RD_ADDR = s.ptr[WORD_ADDR_W:1];
        O_FL_ERASE = (s.st == PFS_LONG) & s.erase;            // [RULE_04]
        O_FL_PROG = (s.st == PFS_LONG) & ~s.erase;            // [RULE_24]
        O_FL_ROW = s.row;                                     // [RULE_05]
        O_FL_BLOCK = s.blk;                                   // [RULE_21]
        O_FL_WDATA = s.wdata;                                 // [RULE_12]
    end

endmodule

// ### pfsseq_flash_model.sv
// Purpose: Behavioural program flash array.
// Assumes: A word read is answered in the cycle after its request.
// Notes: The bus toggles between reads, so stale data is caught.
`timescale 1ns/1ps
module pfsseq_flash_model
    import pfsseq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rd_en,
    input wire logic [WORD_ADDR_W-1:0] i_addr,
    output logic [15:0] o_data = 16'h0000
);
    // Word content is a pure function of the word address
    always_ff @(posedge i_clk) begin
        if (i_rd_en) begin
            o_data <= {i_addr[7:0] ^ 8'h3C, i_addr[7:0]};
        end else begin
            o_data <= ~o_data;
        end
    end
endmodule

// ### pfsseq_sva.sv
// Purpose: Port-level checks of the flash sequencer.
// Assumes: Sees only the ports of the top module.
// Notes: Warm reset cuts a write short, so it disables the checks.
`timescale 1ns/1ps
module pfsseq_sva
    import pfsseq_pkg::*;
#(
    parameter int LONG_WRITE_CYCLES = LONG_WRITE_CYC
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_WARM_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic O_CPU_STALL,
    input wire logic O_NVM_DONE,
    input wire logic O_FL_RD_EN,
    input wire logic O_FL_ERASE,
    input wire logic O_FL_PROG
);
    int stall_cnt;
    logic wr_hit;
    // Length of the current stall
    always_ff @(posedge I_CLK) begin
        if (I_RST || I_WARM_RST || !O_CPU_STALL) begin
            stall_cnt <= 0;
        end else begin
            stall_cnt <= stall_cnt + 1;
        end
    end
    // Completed control write asking for a permitted start
    assign wr_hit = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE &&
        I_PADDR == ADDR_CTRL && I_PWDATA[CTL_WR] &&
        I_PWDATA[CTL_PERMIT] && I_PWDATA[CTL_PSS];
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST || I_WARM_RST);
    sequence s_rd_req;
        O_FL_RD_EN;
    endsequence
    sequence s_rd_ans;
        !O_FL_RD_EN && O_PREADY;
    endsequence
    AST_STALL_LEN: assert property (
        $fell(O_CPU_STALL) |-> stall_cnt == LONG_WRITE_CYCLES)
        else $error("long write length wrong");
    AST_START_CAUSE: assert property (
        $rose(O_CPU_STALL) |-> $past(wr_hit))
        else $error("long write without start request");
    AST_START_KIND: assert property (
        $rose(O_CPU_STALL) |-> O_FL_ERASE == $past(I_PWDATA[CTL_ERASE])
        && O_FL_PROG != O_FL_ERASE)
        else $error("wrong long write kind");
    AST_ARRAY_STALL: assert property (
        (O_FL_ERASE || O_FL_PROG) |-> O_CPU_STALL)
        else $error("array busy without stall");
    AST_DONE: assert property (
        $fell(O_CPU_STALL) |-> O_NVM_DONE)
        else $error("done flag missing");
    AST_HALT_BUS: assert property (
        O_CPU_STALL |-> !O_PREADY)
        else $error("bus answered during stall");
    AST_RD_WALK: assert property (
        s_rd_req |=> s_rd_ans)
        else $error("table read answer late");
    AST_ERR_READY: assert property (
        O_PSLVERR |-> O_PREADY && !O_CPU_STALL)
        else $error("error without ready");
    AST_SHORT_WRITE: assert property (
        I_PSEL && I_PENABLE && O_PREADY && I_PWRITE &&
        I_PADDR == ADDR_CMD && I_PWDATA[CMD_OP]
        |=> !O_CPU_STALL && !O_FL_PROG && !O_FL_ERASE)
        else $error("table write touched the array");
endmodule
bind pfsseq_top pfsseq_sva #(.LONG_WRITE_CYCLES(LONG_WRITE_CYCLES)) sva_i (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_WARM_RST(I_WARM_RST),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
    .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .O_CPU_STALL(O_CPU_STALL),
    .O_NVM_DONE(O_NVM_DONE), .O_FL_RD_EN(O_FL_RD_EN),
    .O_FL_ERASE(O_FL_ERASE), .O_FL_PROG(O_FL_PROG));

// ### tb.sv
// Purpose: Self-checking bench for the program flash sequencer.
// Assumes: Short long-write count keeps the run brief.
// Notes: Master waits on ready; a cycle ceiling ends any hang.
`timescale 1ns/1ps
module tb;
    import pfsseq_pkg::*;
    logic I_CLK = 1'b0;
    logic I_RST = 1'b1;
    logic I_WARM_RST = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rdata, prdata;
    logic pready, pslverr, stall, done, rd_en, erase, prog, err_seen;
    logic [WORD_ADDR_W-1:0] rd_addr;
    logic [15:0] rd_data;
    logic [ROW_W-1:0] row;
    logic [BLK_W-1:0] blk;
    logic [63:0] wdata, exp_w;
    int fails = 0, samples_checked = 0, cyc = 0;
    always #20 I_CLK = ~I_CLK;
    pfsseq_top #(.LONG_WRITE_CYCLES(20)) pfsseq_top_i (.I_CLK(I_CLK),
        .I_RST(I_RST), .I_WARM_RST(I_WARM_RST), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_CPU_STALL(stall), .O_NVM_DONE(done),
        .O_FL_RD_EN(rd_en), .O_FL_RD_ADDR(rd_addr),
        .I_FL_RD_DATA(rd_data), .O_FL_ERASE(erase), .O_FL_ROW(row),
        .O_FL_PROG(prog), .O_FL_BLOCK(blk), .O_FL_WDATA(wdata));
    pfsseq_flash_model pfsseq_flash_model_i (.i_clk(I_CLK),
        .i_rd_en(rd_en), .i_addr(rd_addr), .o_data(rd_data));
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask
    // APB transfer; ready looked at mid-cycle, before its edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n = 0;
        @(posedge I_CLK);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge I_CLK);
        pen <= 1'b1;
        do @(negedge I_CLK); while (pready !== 1'b1 && ++n < 3000);
        if (n >= 3000) fails++;
        rdata = prdata;
        err_seen = pslverr;
        @(posedge I_CLK);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rdata, e);
    endtask
    // Keys back to back, as with interrupts masked
    task automatic start(input logic [31:0] c);
        apb(1'b1, ADDR_KEY, {24'h0, KEY_FIRST});
        apb(1'b1, ADDR_KEY, {24'h0, KEY_SECOND});
        apb(1'b1, ADDR_CTRL, c);
        @(negedge I_CLK);
        chk("stall", 32'(stall), 32'h1);
    endtask
    function automatic logic [7:0] fbyte(input logic [21:0] b);
        logic [15:0] w;
        w = {b[8:1] ^ 8'h3C, b[8:1]};
        return b[0] ? w[15:8] : w[7:0];
    endfunction
    // Pointer after one table op in mode m
    function automatic logic [21:0] pstep(input logic [21:0] b,
        input int m);
        if (m == 0) return b;
        return 22'((m == 2) ? b - 1 : b + 1);
    endfunction
    // Hang guard
    always @(posedge I_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        logic [7:0] d;
        logic [21:0] p, q;
        void'($urandom(64));
        repeat (6) @(posedge I_CLK);
        I_RST <= 1'b0;
        rd(ADDR_CTRL, 32'h0, "ctrl");
        rd(8'h18, 32'h0, "hole");
        chk("slverr", 32'(err_seen), 32'h1);
        $display("test reset done");
        // Every pointer mode, odd and even bytes
        for (int m = 0; m < 4; m++) begin
            p = {2'b00, 8'h01, 11'($urandom), m[0]};
            apb(1'b1, ADDR_PTR, 32'(p));
            apb(1'b1, ADDR_CMD, 32'(m << 1));
            q = (m == 3) ? p + 1 : p;
            rd(ADDR_LATCH, 32'(fbyte(q)), "latch");
            q = pstep(p, m);
            rd(ADDR_PTR, 32'(q), "ptr");
            // Same pointer step on a short write
            apb(1'b1, ADDR_CMD, 32'((m << 1) | 1));
            rd(ADDR_PTR, 32'(pstep(q, m)), "wptr");
        end
        $display("test read done");
        // Fill the eight holds by pre-increment, then program
        p = {2'b00, 8'h02, 9'($urandom), 3'h0};
        apb(1'b1, ADDR_PTR, 32'(p - 1));
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            exp_w[8*i +: 8] = d;
            apb(1'b1, ADDR_LATCH, 32'(d));
            apb(1'b1, ADDR_CMD, 32'h7);
        end
        chk("early", 32'(prog | stall), 32'h0);
        start(32'h86);
        chk("prog", 32'({erase, prog}), 32'h1);
        chk("block", 32'(blk), 32'(p[21:3]));
        chk("wlo", wdata[31:0], exp_w[31:0]);
        chk("whi", wdata[63:32], exp_w[63:32]);
        rd(ADDR_STAT, 32'h1, "done");
        chk("donepin", 32'(done), 32'h1);
        rd(ADDR_CTRL, 32'h84, "ctrl");
        apb(1'b1, ADDR_STAT, 32'h1);
        rd(ADDR_STAT, 32'h0, "clr");
        chk("donelow", 32'(done), 32'h0);
        $display("test program done");
        // Row erase
        p = 22'($urandom);
        apb(1'b1, ADDR_PTR, 32'(p));
        start(32'h96);
        chk("erase", 32'({erase, prog}), 32'h2);
        chk("row", 32'(row), 32'(p[21:6]));
        rd(ADDR_CTRL, 32'h84, "esel");
        $display("test erase done");
        // No permit, key pair split by a pointer write, wrong second key
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, ADDR_KEY, {24'h0, KEY_FIRST});
            if (k == 1) apb(1'b1, ADDR_PTR, 32'h0);
            apb(1'b1, ADDR_KEY, {24'h0, k == 2 ? KEY_FIRST : KEY_SECOND});
            apb(1'b1, ADDR_CTRL, k == 0 ? 32'h82 : 32'h86);
            @(negedge I_CLK);
            chk("nostall", 32'(stall), 32'h0);
            rd(ADDR_CTRL, k == 0 ? 32'h80 : 32'h84, "refused");
        end
        $display("test refuse done");
        // Warm reset in mid-write, then power-on reset
        start(32'h86);
        repeat (5) @(posedge I_CLK);
        I_WARM_RST <= 1'b1;
        repeat (3) @(posedge I_CLK);
        I_WARM_RST <= 1'b0;
        rd(ADDR_CTRL, 32'h88, "abort");
        I_RST <= 1'b1;
        repeat (2) @(posedge I_CLK);
        I_RST <= 1'b0;
        rd(ADDR_CTRL, 32'h0, "por");
        $display("test abort done");
        final_report();
    end
endmodule
